// ### cic_pkg.sv
// Constants and types for the CPU interrupt controller
package cic_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] EN_MAIN_OFS = 8'hA8;
  localparam logic [7:0] IP_MAIN_OFS = 8'hB8;
  localparam logic [7:0] EN_EXT_OFS = 8'hE8;
  localparam logic [7:0] IP_EXT_OFS = 8'hF8;
  localparam logic [7:0] FLAG_LO_OFS = 8'hC0;
  localparam logic [7:0] FLAG_HI_OFS = 8'hC1;
  localparam logic [7:0] FLAG_DBG_OFS = 8'hC2;
  localparam logic [7:0] CTRL_OFS = 8'hC3;
  localparam logic [7:0] DBG_ID_OFS = 8'hC4;
  localparam logic [7:0] EVT_STAT_OFS = 8'hC5;
  localparam logic [7:0] EVT_MASK_OFS = 8'hC6;
  localparam logic [7:0] ACTIVE_OFS = 8'hC7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RST = 8'h00;
  // Arbitrary neutral debug identifier
  localparam logic [7:0] DBG_ID_RST = 8'h5A;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GLOBAL_EN_BIT = 7;
  localparam int CTRL_RELOC_BIT = 0;
  localparam int CTRL_ECC_EN_BIT = 1;
  localparam int CTRL_ECC_PRIO_BIT = 2;
  localparam int EVT_TAKEN_BIT = 0;
  localparam int EVT_DBG_BIT = 1;
  localparam int EVT_BRK_BIT = 2;
  localparam int NUM_SRC = 15;
  localparam int NUM_VEC = 16;
  localparam int SRC_TIMER0 = 1;
  localparam int SRC_TIMER1 = 3;
  localparam int SRC_ECC = 15;
  localparam int FLAG_BRK = 16;
  localparam int FLAG_DBG = 17;
  localparam int NUM_FLAG = 18;

  // ----------------------------------------------------------------
  // Vector addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_NORMAL_BASE = 16'h0003;
  localparam logic [15:0] VEC_RELOC_BASE = 16'h3000;
  localparam logic [15:0] VEC_BRK_OFS = 16'h0080;
  localparam logic [15:0] VEC_DBG_OFS = 16'h00C0;

  // ----------------------------------------------------------------
  // Service levels
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LVL_LO = 2'b00,
    LVL_HI = 2'b01,
    LVL_DBG = 2'b10
  } cic_lvl_t;

endpackage : cic_pkg

// ### cic_flag.sv
// Sticky flag cell: hardware set wins over clear
`timescale 1ns/100ps
module cic_flag (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end
endmodule : cic_flag

// ### cic_top.sv
// CPU interrupt controller: flags, enables, priority, vectors, nesting
`timescale 1ns/100ps

module cic_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic pin_group0_irq,
  input wire logic timer0_overflow_irq,
  input wire logic pin_group1_irq,
  input wire logic timer1_overflow_irq,
  input wire logic uart1_irq,
  input wire logic timer2_irq,
  input wire logic uart2_irq,
  input wire logic i2c_master_irq,
  input wire logic int2_irq,
  input wire logic int3_irq,
  input wire logic int4_irq,
  input wire logic watchdog1_irq,
  input wire logic int6_irq,
  input wire logic int7_irq,
  input wire logic int8_irq,
  input wire logic ecc_irq,
  input wire logic breakpoint_match,
  input wire logic debug_port_mode,
  input wire logic debug_host_req,
  input wire logic [7:0] debug_host_id,
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic cpu_irq_req,
  output logic [15:0] cpu_vec_addr,
  output cic_pkg::cic_lvl_t cpu_irq_level,
  output logic irq_out
);
  import cic_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] interrupt_enable_main_r;
  logic [7:0] extended_irq_enable_reg_r;
  logic [7:0] irq_prio_main_r;
  logic [7:0] irq_prio_ext_r;
  logic [7:0] ctrl_r;
  logic [7:0] dbg_id_r;
  logic [7:0] evt_mask_r;
  logic [7:0] evt_stat_r;
  logic [7:0] rdata_r;
  logic [2:0] act_r;
  logic req_r;
  logic [15:0] vec_r;
  cic_lvl_t lvl_r;
  logic [4:0] sel_r;
  logic irq_out_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire wr_enable_main = wr_en && (addr == EN_MAIN_OFS);
  wire wr_ip = wr_en && (addr == IP_MAIN_OFS);
  wire wr_enable_ext = wr_en && (addr == EN_EXT_OFS);
  wire wr_exip = wr_en && (addr == IP_EXT_OFS);
  wire wr_flo = wr_en && (addr == FLAG_LO_OFS);
  wire wr_fhi = wr_en && (addr == FLAG_HI_OFS);
  wire wr_fdbg = wr_en && (addr == FLAG_DBG_OFS);
  wire wr_ctrl = wr_en && (addr == CTRL_OFS);
  wire wr_id = wr_en && (addr == DBG_ID_OFS);
  wire wr_mask = wr_en && (addr == EVT_MASK_OFS);
  wire rd_stat = rd_en && (addr == EVT_STAT_OFS);

  // ----------------------------------------------------------------
  // Sources, enables and levels
  // ----------------------------------------------------------------
  wire [NUM_VEC-1:0] src_req = {ecc_irq, int8_irq, int7_irq, int6_irq,
    watchdog1_irq, int4_irq, int3_irq, int2_irq, i2c_master_irq,
    uart2_irq, timer2_irq, uart1_irq, timer1_overflow_irq,
    pin_group1_irq, timer0_overflow_irq, pin_group0_irq};
  wire [NUM_VEC-1:0] src_en = {ctrl_r[CTRL_ECC_EN_BIT],
    extended_irq_enable_reg_r, interrupt_enable_main_r[6:0]};
  wire [NUM_VEC-1:0] src_hi = {ctrl_r[CTRL_ECC_PRIO_BIT],
    irq_prio_ext_r, irq_prio_main_r[6:0]};
  wire global_en = interrupt_enable_main_r[GLOBAL_EN_BIT];
  wire reloc = ctrl_r[CTRL_RELOC_BIT];

  // Debug request needs debug port mode and matching identifier
  wire dbg_event = debug_port_mode && debug_host_req
    && (debug_host_id == dbg_id_r);

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  logic [NUM_FLAG-1:0] flag;
  wire [NUM_FLAG-1:0] flag_set = {dbg_event, breakpoint_match, src_req};
  wire ack_t0 = irq_ack && (sel_r == 5'(SRC_TIMER0));
  wire ack_t1 = irq_ack && (sel_r == 5'(SRC_TIMER1));
  wire [NUM_FLAG-1:0] sw_clr = {{(NUM_FLAG-16){wr_fdbg}} & wdata[1:0],
    {8{wr_fhi}} & wdata, {8{wr_flo}} & wdata};
  wire [NUM_FLAG-1:0] hw_clr = NUM_FLAG'({ack_t1, 1'b0, ack_t0, 1'b0});
  wire [NUM_FLAG-1:0] flag_clr = sw_clr | hw_clr;

  // Set-wins cells; a write of ones only ever clears
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAG; gi++) begin : g_flag
      cic_flag u_flag (
        .core_clk(core_clk),
        .rst(rst),
        .set(flag_set[gi]),
        .clr(flag_clr[gi]),
        .q(flag[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  wire [NUM_VEC-1:0] pend = flag[NUM_VEC-1:0] & src_en & {NUM_VEC{global_en}};
  wire [NUM_VEC-1:0] pend_hi = pend & src_hi;
  wire [NUM_VEC-1:0] pend_lo = pend & ~src_hi;

  // Nesting gates: lo needs idle, hi needs no hi/dbg, dbg needs no dbg
  wire dbg_go = flag[FLAG_DBG] && !act_r[LVL_DBG];
  wire brk_go = flag[FLAG_BRK] && !act_r[LVL_DBG];
  wire hi_go = (|pend_hi) && !act_r[LVL_HI] && !act_r[LVL_DBG];
  wire lo_go = (|pend_lo) && (act_r == 3'b000);

  // Natural order: ECC first, then index 0 upward
  function automatic logic [3:0] pick(input logic [NUM_VEC-1:0] p);
    logic [3:0] k;
    k = 4'(SRC_ECC);
    if (!p[SRC_ECC]) begin
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
        if (p[i]) begin
          k = 4'(i);
        end
      end
    end
    return k;
  endfunction : pick

  wire [3:0] idx_hi = pick(pend_hi);
  wire [3:0] idx_lo = pick(pend_lo);
  wire [3:0] idx_win = hi_go ? idx_hi : idx_lo;
  wire [15:0] vec_norm = VEC_NORMAL_BASE + {9'h000, idx_win, 3'b000};
  wire [15:0] vec_src = reloc ? (VEC_RELOC_BASE | vec_norm) : vec_norm;
  wire any_go = dbg_go || brk_go || hi_go || lo_go;

  // ----------------------------------------------------------------
  // Request to the sequencer
  // ----------------------------------------------------------------
  logic req_nxt;
  logic [15:0] vec_nxt;
  cic_lvl_t lvl_nxt;
  logic [4:0] sel_nxt;
  always_comb begin
    req_nxt = any_go && !irq_ack;
    vec_nxt = vec_src;
    lvl_nxt = hi_go ? LVL_HI : LVL_LO;
    sel_nxt = {1'b0, idx_win};
    if (dbg_go) begin
      vec_nxt = VEC_RELOC_BASE | VEC_DBG_OFS;
      lvl_nxt = LVL_DBG;
      sel_nxt = 5'(FLAG_DBG);
    end else if (brk_go) begin
      vec_nxt = VEC_RELOC_BASE | VEC_BRK_OFS;
      lvl_nxt = LVL_DBG;
      sel_nxt = 5'(FLAG_BRK);
    end
  end

  // Service stack: ack pushes the level, return pops the top one
  logic [2:0] act_nxt;
  always_comb begin
    act_nxt = act_r;
    if (irq_ack) begin
      act_nxt[lvl_r] = 1'b1;
    end else if (irq_return) begin
      if (act_r[LVL_DBG]) begin
        act_nxt[LVL_DBG] = 1'b0;
      end else if (act_r[LVL_HI]) begin
        act_nxt[LVL_HI] = 1'b0;
      end else begin
        act_nxt[LVL_LO] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req_r <= 1'b0;
      vec_r <= 16'h0000;
      lvl_r <= LVL_LO;
      sel_r <= 5'h00;
      act_r <= 3'b000;
    end else begin
      req_r <= req_nxt;
      vec_r <= vec_nxt;
      lvl_r <= lvl_nxt;
      sel_r <= sel_nxt;
      act_r <= act_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      interrupt_enable_main_r <= REG_RST;
      extended_irq_enable_reg_r <= REG_RST;
      irq_prio_main_r <= REG_RST;
      irq_prio_ext_r <= REG_RST;
      ctrl_r <= REG_RST;
      dbg_id_r <= DBG_ID_RST;
      evt_mask_r <= REG_RST;
    end else begin
      if (wr_enable_main) interrupt_enable_main_r <= wdata;
      if (wr_enable_ext) extended_irq_enable_reg_r <= wdata;
      if (wr_ip) irq_prio_main_r <= {1'b0, wdata[6:0]};
      if (wr_exip) irq_prio_ext_r <= wdata;
      if (wr_ctrl) ctrl_r <= {5'h00, wdata[2:0]};
      if (wr_id) dbg_id_r <= wdata;
      if (wr_mask) evt_mask_r <= {5'h00, wdata[2:0]};
    end
  end

  // Event status: set wins over the read clear
  wire [7:0] evt_set = {5'h00, breakpoint_match, dbg_event, irq_ack};
  wire [7:0] evt_stat_nxt = evt_set | (rd_stat ? 8'h00 : evt_stat_r);
  wire irq_out_nxt = |(evt_stat_nxt & evt_mask_r);

  // Read mux; unmapped addresses read zero
  logic [7:0] rd_mux;
  always_comb begin
    unique case (addr)
      EN_MAIN_OFS: rd_mux = interrupt_enable_main_r;
      IP_MAIN_OFS: rd_mux = irq_prio_main_r;
      EN_EXT_OFS: rd_mux = extended_irq_enable_reg_r;
      IP_EXT_OFS: rd_mux = irq_prio_ext_r;
      FLAG_LO_OFS: rd_mux = flag[7:0];
      FLAG_HI_OFS: rd_mux = flag[15:8];
      FLAG_DBG_OFS: rd_mux = {6'h00, flag[FLAG_DBG:FLAG_BRK]};
      CTRL_OFS: rd_mux = ctrl_r;
      DBG_ID_OFS: rd_mux = dbg_id_r;
      EVT_STAT_OFS: rd_mux = evt_stat_r;
      EVT_MASK_OFS: rd_mux = evt_mask_r;
      ACTIVE_OFS: rd_mux = {5'h00, act_r};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      evt_stat_r <= REG_RST;
      rdata_r <= REG_RST;
      irq_out_r <= 1'b0;
    end else begin
      evt_stat_r <= evt_stat_nxt;
      rdata_r <= rd_en ? rd_mux : 8'h00;
      irq_out_r <= irq_out_nxt;
    end
  end

  assign rdata = rdata_r;
  assign cpu_irq_req = req_r;
  assign cpu_vec_addr = vec_r;
  assign cpu_irq_level = lvl_r;
  assign irq_out = irq_out_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  flag_hw_set_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !$past(flag_set[0]) && !$past(flag[0]) |-> !flag[0])
    else $error("flag set without a hardware event");

  sample_edge_a: assert property (
    @(posedge core_clk) disable iff (rst)
    src_req[5] |=> flag[5])
    else $error("request not caught at the next edge");

  hi_first_a: assert property (
    @(posedge core_clk) disable iff (rst)
    hi_go && !dbg_go && !brk_go && !irq_ack |=> req_r && lvl_r == LVL_HI)
    else $error("high level request not presented first");

  dbg_first_a: assert property (
    @(posedge core_clk) disable iff (rst)
    dbg_go && !irq_ack |=> req_r && vec_r == 16'h30C0)
    else $error("debug vector not presented");

  brk_vec_a: assert property (
    @(posedge core_clk) disable iff (rst)
    brk_go && !dbg_go && !irq_ack |=> vec_r == 16'h3080)
    else $error("breakpoint vector wrong");

  vec_range_a: assert property (
    @(posedge core_clk) disable iff (rst)
    req_r && lvl_r != LVL_DBG && !$past(reloc) |->
      vec_r[2:0] == 3'b011 && vec_r <= 16'h007B)
    else $error("normal vector out of range");

  reloc_vec_a: assert property (
    @(posedge core_clk) disable iff (rst)
    req_r && $past(reloc) |-> vec_r[15:12] == 4'h3)
    else $error("relocated vector lacks upper nibble");

  global_gate_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !global_en && !flag[FLAG_DBG] && !flag[FLAG_BRK] && !irq_ack
      |=> !req_r)
    else $error("request with global enable off");

  timer_clear_a: assert property (
    @(posedge core_clk) disable iff (rst)
    irq_ack && sel_r == 5'd1 && !src_req[1] |=> !flag[1])
    else $error("timer 0 flag not cleared on service");

  nest_block_a: assert property (
    @(posedge core_clk) disable iff (rst)
    act_r[LVL_HI] && !act_r[LVL_DBG] && !dbg_go && !brk_go && !irq_ack
      |=> !req_r)
    else $error("request preempted a high level routine");

  dbg_match_a: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(flag[FLAG_DBG]) |-> $past(debug_port_mode)
      && $past(debug_host_id) == $past(dbg_id_r))
    else $error("debug flag without a matching request");

endmodule : cic_top

// ### cic_seq_model.sv
// Behavioural model of the CPU sequencer that takes vectors from the controller
`timescale 1ns/100ps
module cic_seq_model
  import cic_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] ack_delay,
  input wire logic cpu_irq_req,
  input wire logic [15:0] cpu_vec_addr,
  input wire cic_pkg::cic_lvl_t cpu_irq_level,
  output logic irq_ack,
  output logic [15:0] seen_vec,
  output cic_pkg::cic_lvl_t seen_lvl,
  output logic [7:0] ack_cnt
);
  import cic_pkg::*;

  logic [3:0] wait_r;

  // --------------------------------------------------------------
  // Acknowledge after a programmable latency
  // --------------------------------------------------------------
  // Only acknowledges while a request stands, one cycle at a time
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_ack <= 1'b0;
      wait_r <= 4'h0;
      seen_vec <= 16'h0000;
      seen_lvl <= LVL_LO;
      ack_cnt <= 8'h00;
    end else begin
      irq_ack <= 1'b0;
      if (cpu_irq_req && !irq_ack) begin
        if (wait_r == ack_delay) begin
          irq_ack <= 1'b1;
          wait_r <= 4'h0;
          seen_vec <= cpu_vec_addr;
          seen_lvl <= cpu_irq_level;
          ack_cnt <= ack_cnt + 8'h01;
        end else begin
          wait_r <= wait_r + 4'h1;
        end
      end else begin
        wait_r <= 4'h0;
      end
    end
  end
endmodule : cic_seq_model

// ### cpu_interrupt_control_tb.sv
// Self-checking testbench for the CPU interrupt controller
`timescale 1ns/100ps
module cpu_interrupt_control_tb;
  import cic_pkg::*;

  logic core_clk;
  logic rst;
  logic [7:0] addr, wdata, rdata, dbg_id, rd_v, ack_cnt;
  logic wr_en, rd_en, brk_in, dbg_mode, dbg_req, irq_return, irq_ack, cpu_irq_req, irq_out;
  logic [15:0] src, cpu_vec_addr, seen_vec, exp_v;
  logic [3:0] ack_delay;
  cic_lvl_t cpu_irq_level, seen_lvl;
  int error_cnt, n_checks;

  always #2.5 core_clk = ~core_clk;

  cic_top DUT (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .pin_group0_irq(src[0]), .timer0_overflow_irq(src[1]), .pin_group1_irq(src[2]),
    .timer1_overflow_irq(src[3]), .uart1_irq(src[4]), .timer2_irq(src[5]), .uart2_irq(src[6]),
    .i2c_master_irq(src[7]), .int2_irq(src[8]), .int3_irq(src[9]), .int4_irq(src[10]),
    .watchdog1_irq(src[11]), .int6_irq(src[12]), .int7_irq(src[13]), .int8_irq(src[14]), .ecc_irq(src[15]),
    .breakpoint_match(brk_in), .debug_port_mode(dbg_mode), .debug_host_req(dbg_req), .debug_host_id(dbg_id),
    .irq_ack(irq_ack), .irq_return(irq_return), .cpu_irq_req(cpu_irq_req), .cpu_vec_addr(cpu_vec_addr),
    .cpu_irq_level(cpu_irq_level), .irq_out(irq_out));

  cic_seq_model seq (.core_clk(core_clk), .rst(rst), .ack_delay(ack_delay), .cpu_irq_req(cpu_irq_req),
    .cpu_vec_addr(cpu_vec_addr), .cpu_irq_level(cpu_irq_level), .irq_ack(irq_ack), .seen_vec(seen_vec),
    .seen_lvl(seen_lvl), .ack_cnt(ack_cnt));

  // --------------------------------------------------------------
  // Bus and check tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("Checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 rd_v = rdata;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk({8'h00, rd_v}, {8'h00, exp});
  endtask : rd_chk

  task automatic pulse(input logic [15:0] m, input logic b);
    @(posedge core_clk);
    src <= m;
    brk_in <= b;
    @(posedge core_clk);
    src <= 16'h0000;
    brk_in <= 1'b0;
  endtask : pulse

  task automatic dbg(input logic mode, input logic [7:0] id, input logic b);
    @(posedge core_clk);
    dbg_mode <= mode;
    dbg_id <= id;
    dbg_req <= 1'b1;
    brk_in <= b;
    @(posedge core_clk);
    dbg_req <= 1'b0;
    brk_in <= 1'b0;
  endtask : dbg

  // Waits for the sequencer to take a vector, then compares it
  task automatic service(input logic [15:0] vec, input logic [15:0] lvl);
    logic [7:0] c0;
    int k;
    c0 = ack_cnt;
    for (k = 0; k < 60 && ack_cnt === c0; k++) begin
      @(posedge core_clk);
      #1;
    end
    if (ack_cnt === c0) begin
      error_cnt++;
      end_sim;
    end
    chk(seen_vec, vec);
    chk(seen_lvl, lvl);
  endtask : service

  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1 chk({15'h0000, cpu_irq_req}, 16'h0000);
    end
  endtask : quiet

  task automatic ret;
    @(posedge core_clk);
    irq_return <= 1'b1;
    @(posedge core_clk);
    irq_return <= 1'b0;
  endtask : ret

  initial begin
    #400us;
    error_cnt++;
    end_sim;
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    {addr, wdata, dbg_id, src} = '0;
    {wr_en, rd_en, brk_in, dbg_mode, dbg_req, irq_return} = '0;
    ack_delay = 4'h0;
    error_cnt = 0;
    n_checks = 0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd_chk(EN_MAIN_OFS, REG_RST);
    rd_chk(DBG_ID_OFS, DBG_ID_RST);
    rd_chk(8'h10, 8'h00);
    wr(FLAG_LO_OFS, 8'hFF);
    rd_chk(FLAG_LO_OFS, 8'h00);
    wr(EN_MAIN_OFS, 8'hA5);
    rd_chk(EN_MAIN_OFS, 8'hA5);
    $display("Test registers done");
    wr(EN_MAIN_OFS, 8'hFF);
    wr(EN_EXT_OFS, 8'hFF);
    for (int r = 0; r < 2; r++) begin
      wr(CTRL_OFS, r ? 8'h03 : 8'h02);
      ack_delay <= r ? 4'h3 : 4'h0;
      for (int i = 0; i < 16; i++) begin
        pulse(16'h0001 << i, 1'b0);
        exp_v = (i == SRC_ECC) ? 16'h007B : VEC_NORMAL_BASE + 16'(8 * i);
        service(exp_v | (r ? VEC_RELOC_BASE : 16'h0000), LVL_LO);
        exp_v = (i == SRC_TIMER0 || i == SRC_TIMER1) ? 16'h0000 : 16'h0001 << (i % 8);
        rd_chk(i < 8 ? FLAG_LO_OFS : FLAG_HI_OFS, exp_v[7:0]);
        wr(i < 8 ? FLAG_LO_OFS : FLAG_HI_OFS, 8'h01 << (i % 8));
        rd_chk(i < 8 ? FLAG_LO_OFS : FLAG_HI_OFS, 8'h00);
        ret;
      end
    end
    $display("Test vectors done");
    wr(CTRL_OFS, 8'h02);
    ack_delay <= 4'h1;
    wr(IP_EXT_OFS, 8'h80);
    pulse(16'hC001, 1'b0);
    service(16'h0073, LVL_HI);
    wr(FLAG_HI_OFS, 8'h40);
    ret;
    service(16'h007B, LVL_LO);
    wr(FLAG_HI_OFS, 8'h80);
    quiet(8);
    ret;
    service(16'h0003, LVL_LO);
    wr(FLAG_LO_OFS, 8'h01);
    ret;
    pulse(16'h0002, 1'b0);
    service(16'h000B, LVL_LO);
    pulse(16'h4000, 1'b0);
    service(16'h0073, LVL_HI);
    wr(FLAG_HI_OFS, 8'h40);
    ret;
    ret;
    wr(IP_MAIN_OFS, 8'h82);
    rd_chk(IP_MAIN_OFS, 8'h02);
    pulse(16'h0003, 1'b0);
    service(16'h000B, LVL_HI);
    rd_chk(ACTIVE_OFS, 8'h02);
    ret;
    service(16'h0003, LVL_LO);
    wr(FLAG_LO_OFS, 8'h01);
    ret;
    wr(IP_MAIN_OFS, 8'h00);
    $display("Test priority done");
    wr(EN_MAIN_OFS, 8'h7F);
    pulse(16'h0001, 1'b0);
    quiet(8);
    pulse(16'h0000, 1'b1);
    service(VEC_RELOC_BASE | VEC_BRK_OFS, LVL_DBG);
    wr(FLAG_DBG_OFS, 8'h01);
    ret;
    wr(FLAG_LO_OFS, 8'h01);
    wr(EN_MAIN_OFS, 8'hFE);
    pulse(16'h0001, 1'b0);
    quiet(8);
    wr(FLAG_LO_OFS, 8'h01);
    dbg(1'b1, ~DBG_ID_RST, 1'b0);
    quiet(8);
    dbg(1'b0, DBG_ID_RST, 1'b0);
    quiet(8);
    dbg(1'b1, DBG_ID_RST, 1'b1);
    service(VEC_RELOC_BASE | VEC_DBG_OFS, LVL_DBG);
    wr(FLAG_DBG_OFS, 8'h02);
    ret;
    service(VEC_RELOC_BASE | VEC_BRK_OFS, LVL_DBG);
    wr(FLAG_DBG_OFS, 8'h01);
    ret;
    $display("Test debug done");
    rd(EVT_STAT_OFS);
    wr(EVT_MASK_OFS, 8'h00);
    pulse(16'h0000, 1'b1);
    service(VEC_RELOC_BASE | VEC_BRK_OFS, LVL_DBG);
    wr(FLAG_DBG_OFS, 8'h01);
    ret;
    repeat (3) @(posedge core_clk);
    #1 chk({15'h0000, irq_out}, 16'h0000);
    wr(EVT_MASK_OFS, 8'h04);
    repeat (3) @(posedge core_clk);
    #1 chk({15'h0000, irq_out}, 16'h0001);
    rd_chk(EVT_STAT_OFS, 8'h05);
    repeat (3) @(posedge core_clk);
    #1 chk({15'h0000, irq_out}, 16'h0000);
    $display("Test event interrupt done");
    end_sim;
  end
endmodule : cpu_interrupt_control_tb
